// File: core/vcm_defines.svh
// Constants for the virtual CPU interface maintenance and control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef VCM_DEFINES_SVH
`define VCM_DEFINES_SVH

// ==========================================================
// Coprocessor access encodings
`define VCM_OPC1_HYP 3'h4
`define VCM_CRN_HYP 4'hc
`define VCM_CRM_CTRL 4'hb
`define VCM_CRM_LIST_HI 3'h7
`define VCM_OPC2_MISR 3'h2
`define VCM_OPC2_VMCR 3'h7

// ==========================================================
// Privilege levels
`define VCM_EL_USER 2'h0
`define VCM_EL_KERNEL 2'h1
`define VCM_EL_HYP 2'h2
`define VCM_EL_MON 2'h3

// ==========================================================
// Maintenance status field positions
`define VCM_MISR_G1D 7
`define VCM_MISR_G1E 6
`define VCM_MISR_G0D 5
`define VCM_MISR_G0E 4
`define VCM_MISR_NP 3
`define VCM_MISR_ENP 2
`define VCM_MISR_U 1
`define VCM_MISR_EOI 0
`define VCM_MISR_RESET 32'h0000_0000

// ==========================================================
// VM control field positions
`define VCM_VMCR_PMR_HI 31
`define VCM_VMCR_PMR_LO 24
`define VCM_VMCR_BP0_HI 23
`define VCM_VMCR_BP0_LO 21
`define VCM_VMCR_BP1_HI 20
`define VCM_VMCR_BP1_LO 18
`define VCM_VMCR_EOIM 9
`define VCM_VMCR_LOW_HI 4
`define VCM_VMCR_CBPR 4
`define VCM_VMCR_ENG1 1
`define VCM_VMCR_ENG0 0
`define VCM_VMCR_RESET 32'h0000_0000

// ==========================================================
// List entry upper half fields
`define VCM_LR_STATE_HI 31
`define VCM_LR_STATE_LO 30
`define VCM_LR_GROUP 28
`define VCM_LR_PRIO_HI 23
`define VCM_LR_PRIO_LO 16
`define VCM_LR_WMASK 32'hf0ff_1fff
`define VCM_LR_RESET 32'h0000_0000

`endif

// File: core/vcm_pkg.sv
// Types for the virtual CPU interface maintenance and control block.
// Assumes vcm_defines.svh on the include path.
package vcm_pkg;
`include "vcm_defines.svh"

	// ==========================================================
	// List entry state encoding
	typedef enum logic [1:0] {
		VCM_ST_INVALID = 2'b00,
		VCM_ST_PENDING = 2'b01,
		VCM_ST_ACTIVE = 2'b10,
		VCM_ST_PEND_ACT = 2'b11
	} vcm_state_e;

	// ==========================================================
	// Access outcome
	typedef enum logic [1:0] {
		VCM_ACC_OK = 2'b00,
		VCM_ACC_UNDEF = 2'b01,
		VCM_ACC_TRAP = 2'b10
	} vcm_acc_e;

	typedef logic [7:0] vcm_prio_t;
endpackage : vcm_pkg

// File: core/vcm_ctrl.sv
// Maintenance status, VM control and list entry upper halves of a
// virtual CPU interface, reached by coprocessor register accesses.
// Assumes hypervisor control bits and end-of-interrupt sources come
// from logic on sys_clk; the lower halves of list entries live elsewhere.
//
// How it works
// - status bit 7: group1 disabled, enable set
// - status bit 6: group1 enabled, enable set
// - status bit 5: group0 disabled, enable set
// - status bit 4: group0 enabled, enable set
// - status bit 3: no entry pending
// - status bit 2: end-of-interrupt counter nonzero
// - status bit 1: at most one entry valid
// - status bit 0: any end-of-interrupt vector bit
// - status read-only, upper bits zero, resets zero
// - signal only priorities above the mask
// - group0 binary point splits group priority
// - group1 binary point used unless common selected
// - split mode chooses drop versus deactivate
// - control fields aliased, reserved bits read zero
// - upper half written without touching lower
// - undefined at hypervisor level without enable, trap when configured
// - two-bit entry state encoding
`timescale 1ns/1ps
`include "vcm_defines.svh"

module vcm_ctrl #(
	parameter int NUM_LR = 16,
	parameter int EOI_CNT_W = 5
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	// System register access port
	input wire logic sreg_valid,
	input wire logic sreg_write,
	input wire logic [1:0] sreg_level,
	input wire logic [2:0] sreg_opc1,
	input wire logic [3:0] sreg_crn,
	input wire logic [3:0] sreg_crm,
	input wire logic [2:0] sreg_opc2,
	input wire logic [31:0] sreg_wdata,
	output logic sreg_done,
	output logic [31:0] sreg_rdata,
	output vcm_pkg::vcm_acc_e sreg_result,
	// Enables and trap control
	input wire logic hyp_sysreg_enable_reg,
	input wire logic group12_trap_control,
	// Hypervisor control bits
	input wire logic grp1_disabled_irq_enable,
	input wire logic grp1_enabled_irq_enable,
	input wire logic grp0_disabled_irq_enable,
	input wire logic grp0_enabled_irq_enable,
	input wire logic no_pending_irq_enable,
	input wire logic entry_absent_irq_enable,
	input wire logic underflow_irq_enable,
	input wire logic [EOI_CNT_W-1:0] end_of_intr_counter,
	input wire logic [NUM_LR-1:0] end_of_intr_status_vector,
	// Virtual interface requests
	input wire logic [7:0] running_priority,
	input wire logic veoi_valid,
	input wire logic [3:0] veoi_entry,
	input wire logic vdir_valid,
	input wire logic [3:0] vdir_entry,
	// Results
	output logic maint_irq,
	output logic virq_pending,
	output logic [3:0] virq_entry,
	output logic prio_drop,
	output logic deact_done
);
	import vcm_pkg::*;

	// ==========================================================
	// Storage
	logic [31:0] list_hi [NUM_LR];
	logic [31:0] misr;
	vcm_prio_t virtual_priority_mask;
	logic [2:0] grp0_binary_point;
	logic [2:0] grp1_binary_point;
	logic split_deactivate_mode;
	logic [4:0] vmcr_low;
	logic common_binary_point_select;
	logic virtual_grp1_enable;
	logic virtual_grp0_enable;

	assign common_binary_point_select = vmcr_low[`VCM_VMCR_CBPR];
	assign virtual_grp1_enable = vmcr_low[`VCM_VMCR_ENG1];
	assign virtual_grp0_enable = vmcr_low[`VCM_VMCR_ENG0];

	// ==========================================================
	// Functions
	function automatic vcm_state_e entry_state(input logic [31:0] e);
		entry_state = vcm_state_e'(e[`VCM_LR_STATE_HI:`VCM_LR_STATE_LO]);
	endfunction : entry_state

	// Pending or pending-and-active: entry still asks to be signalled
	function automatic logic entry_pending(input logic [31:0] e);
		entry_pending = entry_state(e) inside {VCM_ST_PENDING, VCM_ST_PEND_ACT};
	endfunction : entry_pending

	// Group priority: the low shift bits, below bit shift, are masked off
	function automatic vcm_prio_t group_prio(input vcm_prio_t p, input logic [3:0] shift);
		group_prio = p & vcm_prio_t'(8'hff << shift);
	endfunction : group_prio

	// ==========================================================
	// Access decode
	logic is_ctrl;
	logic is_misr;
	logic is_vmcr;
	logic is_list;
	logic [3:0] acc_entry;
	logic list_in_range;
	logic mapped;
	vcm_acc_e next_result;

	assign is_ctrl = (sreg_opc1 == `VCM_OPC1_HYP) && (sreg_crn == `VCM_CRN_HYP);
	assign is_misr = is_ctrl && (sreg_crm == `VCM_CRM_CTRL) && (sreg_opc2 == `VCM_OPC2_MISR);
	assign is_vmcr = is_ctrl && (sreg_crm == `VCM_CRM_CTRL) && (sreg_opc2 == `VCM_OPC2_VMCR);
	assign is_list = is_ctrl && (sreg_crm[3:1] == `VCM_CRM_LIST_HI);
	assign acc_entry = {sreg_crm[0], sreg_opc2};
	assign list_in_range = 32'(acc_entry) < NUM_LR;
	// Status is read-only: a write to it is undefined
	assign mapped = (is_misr && !sreg_write) || is_vmcr || (is_list && list_in_range);

	always_comb begin
		next_result = VCM_ACC_UNDEF;
		unique case (sreg_level)
			`VCM_EL_HYP: begin
				if (hyp_sysreg_enable_reg && mapped) begin
					next_result = VCM_ACC_OK;
				end
			end
			`VCM_EL_KERNEL: begin
				// Without the trap a kernel access is undefined
				if (group12_trap_control) begin
					next_result = VCM_ACC_TRAP;
				end
			end
			`VCM_EL_MON: begin
				// Monitor level skips the hypervisor enable
				if (mapped) begin
					next_result = VCM_ACC_OK;
				end
			end
			`VCM_EL_USER: begin
				next_result = VCM_ACC_UNDEF;
			end
		endcase
	end

	logic acc_ok;
	logic do_write;
	assign acc_ok = sreg_valid && (next_result == VCM_ACC_OK);
	assign do_write = acc_ok && sreg_write;

	// ==========================================================
	// VM control register
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			virtual_priority_mask <= vcm_prio_t'(`VCM_VMCR_RESET);
			grp0_binary_point <= 3'h0;
			grp1_binary_point <= 3'h0;
			split_deactivate_mode <= 1'b0;
			vmcr_low <= 5'h00;
		end else if (clk_en && do_write && is_vmcr) begin
			// Reserved bits are dropped on write
			virtual_priority_mask <= sreg_wdata[`VCM_VMCR_PMR_HI:`VCM_VMCR_PMR_LO];
			grp0_binary_point <= sreg_wdata[`VCM_VMCR_BP0_HI:`VCM_VMCR_BP0_LO];
			grp1_binary_point <= sreg_wdata[`VCM_VMCR_BP1_HI:`VCM_VMCR_BP1_LO];
			split_deactivate_mode <= sreg_wdata[`VCM_VMCR_EOIM];
			// Bits 3:2 are kept for save and restore only
			vmcr_low <= sreg_wdata[`VCM_VMCR_LOW_HI:0];
		end
	end

	logic [31:0] vmcr_view;
	assign vmcr_view = {virtual_priority_mask, grp0_binary_point, grp1_binary_point,
		8'h00, split_deactivate_mode, 4'h0, vmcr_low};

	// ==========================================================
	// End-of-interrupt and deactivate handling
	logic deact_req;
	logic [3:0] deact_idx;
	always_comb begin
		deact_req = 1'b0;
		deact_idx = veoi_entry;
		if (!split_deactivate_mode) begin
			// Deactivate register ignored in this mode
			deact_req = veoi_valid;
		end else begin
			deact_req = vdir_valid;
			deact_idx = vdir_entry;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prio_drop <= 1'b0;
			deact_done <= 1'b0;
		end else if (clk_en) begin
			prio_drop <= veoi_valid;
			// An entry index past the list is dropped
			deact_done <= deact_req && (32'(deact_idx) < NUM_LR);
		end
	end

	// ==========================================================
	// List entry upper halves
	// A software write wins over a deactivate to the same entry.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_LR; i++) begin
				list_hi[i] <= `VCM_LR_RESET;
			end
		end else if (clk_en) begin
			for (int i = 0; i < NUM_LR; i++) begin
				if (do_write && is_list && (acc_entry == 4'(i))) begin
					// Reserved fields always read zero
					list_hi[i] <= sreg_wdata & `VCM_LR_WMASK;
				end else if (deact_req && (deact_idx == 4'(i))) begin
					list_hi[i][`VCM_LR_STATE_HI] <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Maintenance status
	logic any_pending;
	logic [5:0] valid_count;
	logic [31:0] next_misr;
	always_comb begin
		any_pending = 1'b0;
		valid_count = 6'h00;
		for (int i = 0; i < NUM_LR; i++) begin
			if (entry_pending(list_hi[i])) begin
				any_pending = 1'b1;
			end
			// Underflow counts every entry not invalid
			if (entry_state(list_hi[i]) != VCM_ST_INVALID) begin
				valid_count = valid_count + 6'h01;
			end
		end
		next_misr = `VCM_MISR_RESET;
		next_misr[`VCM_MISR_G1D] = grp1_disabled_irq_enable && !virtual_grp1_enable;
		next_misr[`VCM_MISR_G1E] = grp1_enabled_irq_enable && virtual_grp1_enable;
		next_misr[`VCM_MISR_G0D] = grp0_disabled_irq_enable && !virtual_grp0_enable;
		next_misr[`VCM_MISR_G0E] = grp0_enabled_irq_enable && virtual_grp0_enable;
		next_misr[`VCM_MISR_NP] = no_pending_irq_enable && !any_pending;
		next_misr[`VCM_MISR_ENP] = entry_absent_irq_enable
			&& (end_of_intr_counter != '0);
		next_misr[`VCM_MISR_U] = underflow_irq_enable && (valid_count <= 6'h01);
		next_misr[`VCM_MISR_EOI] = |end_of_intr_status_vector;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			misr <= `VCM_MISR_RESET;
			maint_irq <= 1'b0;
		end else if (clk_en) begin
			misr <= next_misr;
			maint_irq <= |next_misr;
		end
	end

	// ==========================================================
	// Pending virtual interrupt selection
	logic next_found;
	logic [3:0] next_idx;
	vcm_prio_t best_prio;
	always_comb begin
		vcm_prio_t p;
		logic grp;
		logic [3:0] shift;
		p = '0;
		grp = 1'b0;
		shift = 4'h0;
		next_found = 1'b0;
		next_idx = 4'h0;
		best_prio = 8'hff;
		for (int i = 0; i < NUM_LR; i++) begin
			p = list_hi[i][`VCM_LR_PRIO_HI:`VCM_LR_PRIO_LO];
			grp = list_hi[i][`VCM_LR_GROUP];
			// Common point makes group 1 follow the group 0 split
			if (!grp || common_binary_point_select) begin
				shift = {1'b0, grp0_binary_point} + 4'h1;
			end else begin
				shift = {1'b0, grp1_binary_point};
			end
			if (entry_pending(list_hi[i])
				&& (grp ? virtual_grp1_enable : virtual_grp0_enable)
				&& (p < virtual_priority_mask)
				&& (group_prio(p, shift) < running_priority)
				&& (!next_found || (p < best_prio))) begin
				next_found = 1'b1;
				next_idx = 4'(i);
				best_prio = p;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			virq_pending <= 1'b0;
			virq_entry <= 4'h0;
		end else if (clk_en) begin
			virq_pending <= next_found;
			virq_entry <= next_idx;
		end
	end

	// ==========================================================
	// Access response
	logic [31:0] next_rdata;
	always_comb begin
		// Refused accesses return zero so nothing leaks
		next_rdata = 32'h0000_0000;
		if (acc_ok && !sreg_write) begin
			if (is_misr) begin
				next_rdata = misr;
			end else if (is_vmcr) begin
				next_rdata = vmcr_view;
			end else if (is_list) begin
				next_rdata = list_hi[acc_entry];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sreg_done <= 1'b0;
			sreg_rdata <= 32'h0000_0000;
			sreg_result <= VCM_ACC_OK;
		end else if (clk_en) begin
			sreg_done <= sreg_valid;
			sreg_rdata <= next_rdata;
			sreg_result <= sreg_valid ? next_result : VCM_ACC_OK;
		end
	end
endmodule : vcm_ctrl

// File: dv/vcm_ctrl_checker.sv
// Concurrent checks on the ports of the maintenance and control block.
// Assumes the bench drives clk_en; bound to vcm_ctrl below.
`timescale 1ns/1ps
module vcm_ctrl_checker #(
	parameter int NUM_LR = 16,
	parameter int EOI_CNT_W = 5
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic sreg_valid,
	input wire logic sreg_write,
	input wire logic [1:0] sreg_level,
	input wire logic [3:0] sreg_crm,
	input wire logic [2:0] sreg_opc2,
	input wire logic sreg_done,
	input wire logic [31:0] sreg_rdata,
	input wire vcm_pkg::vcm_acc_e sreg_result,
	input wire logic group12_trap_control,
	input wire logic entry_absent_irq_enable,
	input wire logic [EOI_CNT_W-1:0] end_of_intr_counter,
	input wire logic [NUM_LR-1:0] end_of_intr_status_vector,
	input wire logic veoi_valid,
	input wire logic vdir_valid,
	input wire logic maint_irq,
	input wire logic prio_drop,
	input wire logic deact_done
);
	import vcm_pkg::*;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	// ==========================================================
	// Register reads at the hypervisor control encodings
	sequence s_rd(logic [2:0] o2);
		sreg_valid && !sreg_write && sreg_crm == 4'hb && sreg_opc2 == o2;
	endsequence
	sequence s_ok;
		sreg_result == VCM_ACC_OK;
	endsequence
	property p_done; sreg_valid && clk_en |=> sreg_done; endproperty
	a_done: assert property (p_done) else $error("access not answered");
	property p_trap;
		sreg_valid && sreg_level == 2'h1 && group12_trap_control |=> sreg_result == VCM_ACC_TRAP;
	endproperty
	a_trap: assert property (p_trap) else $error("kernel access not trapped");
	property p_user;
		sreg_valid && clk_en && sreg_level == 2'h0 |=> sreg_result == VCM_ACC_UNDEF;
	endproperty
	a_user: assert property (p_user) else $error("user access not refused");
	property p_refz; sreg_done && sreg_result != VCM_ACC_OK |-> sreg_rdata == 32'h0; endproperty
	a_refz: assert property (p_refz) else $error("refused access leaked data");
	property p_misr; s_rd(3'h2) ##1 s_ok |-> sreg_rdata[31:8] == 24'h0; endproperty
	a_misr: assert property (p_misr) else $error("status upper bits set");
	property p_vmcr;
		s_rd(3'h7) ##1 s_ok |-> sreg_rdata[17:10] == 8'h0 && sreg_rdata[8:5] == 4'h0;
	endproperty
	a_vmcr: assert property (p_vmcr) else $error("control reserved bits set");
	property p_eoi; |end_of_intr_status_vector |=> maint_irq; endproperty
	a_eoi: assert property (p_eoi) else $error("eoi vector gave no request");
	property p_enp;
		entry_absent_irq_enable && end_of_intr_counter != '0 |=> maint_irq;
	endproperty
	a_enp: assert property (p_enp) else $error("eoi count gave no request");
	property p_drop; veoi_valid |=> prio_drop; endproperty
	a_drop: assert property (p_drop) else $error("no priority drop");
	property p_deact; deact_done |-> $past(vdir_valid) || $past(veoi_valid); endproperty
	a_deact: assert property (p_deact) else $error("stray deactivate");
endmodule : vcm_ctrl_checker

bind vcm_ctrl vcm_ctrl_checker #(.NUM_LR(NUM_LR), .EOI_CNT_W(EOI_CNT_W)) u_vcm_ctrl_checker (
	.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .sreg_valid(sreg_valid),
	.sreg_write(sreg_write),
	.sreg_level(sreg_level), .sreg_crm(sreg_crm), .sreg_opc2(sreg_opc2),
	.sreg_done(sreg_done), .sreg_rdata(sreg_rdata), .sreg_result(sreg_result),
	.group12_trap_control(group12_trap_control),
	.entry_absent_irq_enable(entry_absent_irq_enable),
	.end_of_intr_counter(end_of_intr_counter),
	.end_of_intr_status_vector(end_of_intr_status_vector), .veoi_valid(veoi_valid),
	.vdir_valid(vdir_valid), .maint_irq(maint_irq), .prio_drop(prio_drop),
	.deact_done(deact_done));

// File: dv/vcm_ctrl_tb.sv
// Self-checking bench for the maintenance and control block.
// Assumes the default parameters; clk_en, opc1 and CRn are driven here.
`timescale 1ns/1ps
module vcm_ctrl_tb;
	import vcm_pkg::*;
	logic sys_clk = 0, reset = 1, sreg_valid = 0, sreg_write = 0, hen = 1, trp = 0;
	logic ce = 1;
	logic [1:0] sreg_level = 2'h2;
	logic [3:0] sreg_crm = 4'h0, ve = 4'h0, vd = 4'h0, virq_entry, cn = 4'hc;
	logic [2:0] sreg_opc2 = 3'h0, o1 = 3'h4;
	logic [31:0] sreg_wdata = 32'h0, sreg_rdata, rd;
	logic [6:0] ien = 7'h0;
	logic [4:0] cnt = 5'h0;
	logic [15:0] vec = 16'h0;
	logic [7:0] rprio = 8'hff;
	logic sreg_done, veoi = 0, vdir = 0, maint_irq, virq_pending, prio_drop, deact_done;
	vcm_acc_e sreg_result, rs;
	int fail_count = 0, compares = 0;
	// Enables g1d,g1e,g0d,g0e,np,enp,u at 30:24; eng at 17:16; vector 12; count 11:8
	logic [31:0] rows [12] = '{32'h0000_0000, 32'h4000_0080, 32'h2002_0040, 32'h2000_0000,
		32'h1000_0020, 32'h0801_0010, 32'h0400_0008, 32'h0200_0304, 32'h0200_0000,
		32'h0100_0002, 32'h0000_1001, 32'h4002_0000};
	always #50 sys_clk = ~sys_clk;
	vcm_ctrl u_vcm_ctrl (.sys_clk(sys_clk), .reset(reset), .clk_en(ce),
		.sreg_valid(sreg_valid), .sreg_write(sreg_write), .sreg_level(sreg_level),
		.sreg_opc1(o1), .sreg_crn(cn), .sreg_crm(sreg_crm), .sreg_opc2(sreg_opc2),
		.sreg_wdata(sreg_wdata), .sreg_done(sreg_done), .sreg_rdata(sreg_rdata),
		.sreg_result(sreg_result), .hyp_sysreg_enable_reg(hen),
		.group12_trap_control(trp), .grp1_disabled_irq_enable(ien[6]),
		.grp1_enabled_irq_enable(ien[5]), .grp0_disabled_irq_enable(ien[4]),
		.grp0_enabled_irq_enable(ien[3]), .no_pending_irq_enable(ien[2]),
		.entry_absent_irq_enable(ien[1]), .underflow_irq_enable(ien[0]),
		.end_of_intr_counter(cnt), .end_of_intr_status_vector(vec),
		.running_priority(rprio), .veoi_valid(veoi), .veoi_entry(ve),
		.vdir_valid(vdir), .vdir_entry(vd), .maint_irq(maint_irq),
		.virq_pending(virq_pending), .virq_entry(virq_entry), .prio_drop(prio_drop),
		.deact_done(deact_done));
	// ==========================================================
	// Tasks
	task automatic end_of_test;
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("Error %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask : chk
	task automatic acc(input logic [1:0] lv, input logic wr, input logic [3:0] cm,
		input logic [2:0] o2, input logic [31:0] wd);
		sreg_valid <= 1'b1;
		sreg_write <= wr;
		sreg_level <= lv;
		sreg_crm <= cm;
		sreg_opc2 <= o2;
		sreg_wdata <= wd;
		@(posedge sys_clk);
		sreg_valid <= 1'b0;
		@(negedge sys_clk);
		chk({31'h0, sreg_done}, 32'h1);
		rd = sreg_rdata;
		rs = sreg_result;
		@(posedge sys_clk);
	endtask : acc
	task automatic vm(input logic [31:0] wd);
		acc(2'h2, 1'b1, 4'hb, 3'h7, wd);
	endtask : vm
	task automatic lr(input logic [3:0] n, input logic wr, input logic [31:0] wd);
		acc(2'h2, wr, {3'h7, n[3]}, n[2:0], wd);
	endtask : lr
	task automatic st(input logic [7:0] exp);
		@(posedge sys_clk);
		acc(2'h2, 1'b0, 4'hb, 3'h2, 32'h0);
		chk(rd, {24'h0, exp});
		@(negedge sys_clk);
		chk({31'h0, maint_irq}, {31'h0, |exp});
		@(posedge sys_clk);
	endtask : st
	task automatic rf(input logic [1:0] lv, input logic tp, input logic he, input logic wr,
		input logic [3:0] cm, input logic [2:0] o2, input vcm_acc_e ex);
		trp <= tp;
		hen <= he;
		acc(lv, wr, cm, o2, 32'hffff_ffff);
		chk({30'h0, rs}, {30'h0, ex});
		chk(rd, 32'h0);
	endtask : rf
	task automatic pulse(input logic d, input logic [3:0] n);
		veoi <= !d;
		vdir <= d;
		ve <= n;
		vd <= n;
		@(posedge sys_clk);
		veoi <= 1'b0;
		vdir <= 1'b0;
		@(negedge sys_clk);
		chk({31'h0, d ? deact_done : prio_drop}, 32'h1);
		@(posedge sys_clk);
	endtask : pulse
	task automatic vq(input logic [31:0] wd, input logic [4:0] exp);
		vm(wd);
		@(negedge sys_clk);
		chk({27'h0, virq_pending, exp[4] ? virq_entry : 4'h0}, {27'h0, exp});
		@(posedge sys_clk);
	endtask : vq
	// ==========================================================
	// Sequence
	initial begin
		#1ms;
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		foreach (rows[i]) begin
			ien <= rows[i][30:24];
			cnt <= {1'b0, rows[i][11:8]};
			vec <= {rows[i][12], 15'h0};
			vm({30'h0, rows[i][17:16]});
			st(rows[i][7:0]);
		end
		ien <= 7'h0;
		rf(2'h0, 1'b0, 1'b1, 1'b1, 4'hb, 3'h7, VCM_ACC_UNDEF);
		rf(2'h1, 1'b1, 1'b1, 1'b1, 4'hb, 3'h7, VCM_ACC_TRAP);
		rf(2'h1, 1'b0, 1'b1, 1'b1, 4'hb, 3'h7, VCM_ACC_UNDEF);
		rf(2'h2, 1'b0, 1'b0, 1'b1, 4'hb, 3'h7, VCM_ACC_UNDEF);
		rf(2'h3, 1'b0, 1'b0, 1'b0, 4'hb, 3'h2, VCM_ACC_OK);
		o1 <= 3'h5;
		rf(2'h2, 1'b0, 1'b1, 1'b0, 4'hb, 3'h7, VCM_ACC_UNDEF);
		o1 <= 3'h4;
		cn <= 4'hb;
		rf(2'h2, 1'b0, 1'b1, 1'b0, 4'hb, 3'h7, VCM_ACC_UNDEF);
		cn <= 4'hc;
		rf(2'h2, 1'b0, 1'b1, 1'b1, 4'hb, 3'h2, VCM_ACC_UNDEF);
		rf(2'h2, 1'b0, 1'b1, 1'b0, 4'ha, 3'h7, VCM_ACC_UNDEF);
		acc(2'h2, 1'b0, 4'hb, 3'h7, 32'h0);
		chk(rd, 32'h0000_0002);
		vm(32'hffff_ffff);
		acc(2'h2, 1'b0, 4'hb, 3'h7, 32'h0);
		chk(rd, 32'hfffc_021f);
		ce <= 1'b0;
		sreg_valid <= 1'b1;
		sreg_write <= 1'b1;
		sreg_opc2 <= 3'h7;
		sreg_wdata <= 32'h0;
		@(posedge sys_clk);
		sreg_valid <= 1'b0;
		ce <= 1'b1;
		@(negedge sys_clk);
		chk({31'h0, sreg_done}, 32'h0);
		@(posedge sys_clk);
		acc(2'h2, 1'b0, 4'hb, 3'h7, 32'h0);
		chk(rd, 32'hfffc_021f);
		lr(4'hf, 1'b1, 32'hffff_ffff);
		lr(4'hf, 1'b0, 32'h0);
		chk(rd, 32'hf0ff_1fff);
		ien <= 7'h05;
		st(8'h02);
		lr(4'h0, 1'b1, 32'h4010_0000);
		st(8'h00);
		ien <= 7'h00;
		vm(32'h0);
		pulse(1'b0, 4'hf);
		lr(4'hf, 1'b0, 32'h0);
		chk(rd, 32'h70ff_1fff);
		vm(32'h0000_0200);
		lr(4'hf, 1'b1, 32'hffff_ffff);
		pulse(1'b0, 4'hf);
		lr(4'hf, 1'b0, 32'h0);
		chk(rd, 32'hf0ff_1fff);
		pulse(1'b1, 4'hf);
		lr(4'hf, 1'b0, 32'h0);
		chk(rd, 32'h70ff_1fff);
		vq(32'h8000_0001, 5'h10);
		vq(32'h1000_0001, 5'h00);
		rprio <= 8'h10;
		vq(32'h8000_0001, 5'h00);
		vq(32'h8080_0001, 5'h10);
		lr(4'h1, 1'b1, 32'h5010_0000);
		vq(32'h8010_0002, 5'h00);
		vq(32'h8014_0002, 5'h11);
		vq(32'h8080_0012, 5'h11);
		reset <= 1'b1;
		@(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		acc(2'h2, 1'b0, 4'hb, 3'h7, 32'h0);
		chk(rd, 32'h0);
		lr(4'hf, 1'b0, 32'h0);
		chk(rd, 32'h0);
		st(8'h00);
		end_of_test();
	end
endmodule : vcm_ctrl_tb
